/* File: core/pmse_top.sv */
// Performance monitoring time base, near-end second events and availability filter.
`default_nettype none
`include "pmse_params.svh"

module pmse_top
    import pmse_pkg::*;
#(
    parameter int EBC_W = 16
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             element_time_tick,
    input  wire logic             element_time_preset,
    input  wire logic [16:0]      element_time_of_day,
    input  wire logic             defect_second_flag,
    input  wire logic [EBC_W-1:0] errored_block_count,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [31:0]      reg_wr_data,
    input  wire logic             reg_wr_en,
    input  wire logic             reg_rd_en,
    output var  logic [31:0]      reg_rd_data,
    output var  logic             irq,
    output var  logic             second_tick,
    output var  logic             quarter_hour_tick,
    output var  logic             daily_tick,
    output var  logic [16:0]      delayed_time_base,
    output var  logic             errored_second_event,
    output var  logic             severe_errored_second_event,
    output var  logic [EBC_W-1:0] background_block_errors,
    output var  logic             avail_errored_second,
    output var  logic             avail_severe_errored_second,
    output var  logic [EBC_W-1:0] avail_background_block_errors,
    output var  logic             unavailable_second_out,
    output var  logic             unavailable_state,
    output var  logic             unavailable_change
);

    localparam int DEPTH = `PMSE_DLY_DEPTH;
    localparam logic [EBC_W-1:0] THR_STD   = EBC_W'(`PMSE_THR_STD);
    localparam logic [EBC_W-1:0] THR_VIDEO = EBC_W'(`PMSE_THR_VIDEO);
    localparam logic [EBC_W-1:0] EBC_ZERO  = '0;
    localparam logic [EBC_W-1:0] EBC_ONE   = EBC_W'(1);

    ////////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Steps a time of day forward by one second, wrapping at midnight.
    function automatic pmse_tod_t pmse_inc(input pmse_tod_t t);
        if (t == `PMSE_SEC_PER_DAY - 17'h00001) begin
            return 17'h00000;
        end
        return t + 17'h00001;
    endfunction : pmse_inc

    // Moves a time of day back by the time base delay, wrapping at midnight.
    function automatic pmse_tod_t pmse_back(input pmse_tod_t t);
        if (t >= `PMSE_TB_DELAY) begin
            return t - `PMSE_TB_DELAY;
        end
        return t + `PMSE_SEC_PER_DAY - `PMSE_TB_DELAY;
    endfunction : pmse_back

    // Second of day at which a given quarter hour starts.
    function automatic pmse_tod_t pmse_qtr_start(input pmse_qtr_t q);
        return pmse_tod_t'({10'h000, q}) * `PMSE_SEC_PER_QTR;
    endfunction : pmse_qtr_start

    // Forces an unconnected count to zero.
    function automatic logic [EBC_W-1:0] pmse_gate(input logic conn,
                                                   input logic [EBC_W-1:0] v);
        return conn ? v : EBC_ZERO;
    endfunction : pmse_gate

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [31:0]           ctrl_r;
    logic [`PMSE_EV_W-1:0] status_r;
    logic [`PMSE_EV_W-1:0] status_nxt;
    logic [`PMSE_EV_W-1:0] mask_r;
    logic [`PMSE_EV_W-1:0] event_set;
    logic [`PMSE_EV_W-1:0] status_clr;
    logic [31:0]           rd_data_r;
    logic [31:0]           rd_mux;
    logic                  irq_r;

    logic                  ds_conn;
    logic                  ebc_conn;
    logic                  bbe_conn;
    logic                  es_conn;
    logic                  ses_conn;
    logic                  video_layer;
    pmse_qtr_t             start_qtr;

    assign ds_conn     = ctrl_r[`PMSE_CTRL_DS_CONN];
    assign ebc_conn    = ctrl_r[`PMSE_CTRL_EBC_CONN];
    assign bbe_conn    = ctrl_r[`PMSE_CTRL_BBE_CONN];
    assign es_conn     = ctrl_r[`PMSE_CTRL_ES_CONN];
    assign ses_conn    = ctrl_r[`PMSE_CTRL_SES_CONN];
    assign video_layer = ctrl_r[`PMSE_CTRL_VIDEO];
    assign start_qtr   = ctrl_r[`PMSE_CTRL_START_HI:`PMSE_CTRL_START_LO];

    // A start quarter beyond the last of the day is stored as midnight.
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= `PMSE_CTRL_RST;
        end else if (reg_wr_en && reg_addr == `PMSE_ADDR_CTRL) begin
            ctrl_r <= reg_wr_data;
            if (reg_wr_data[`PMSE_CTRL_START_HI:`PMSE_CTRL_START_LO] >= `PMSE_QTR_PER_DAY) begin
                ctrl_r[`PMSE_CTRL_START_HI:`PMSE_CTRL_START_LO] <= 7'h00;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mask_r <= `PMSE_EV_RST;
        end else if (reg_wr_en && reg_addr == `PMSE_ADDR_MASK) begin
            mask_r <= reg_wr_data[`PMSE_EV_W-1:0];
        end
    end

    // Write one to clear; a new event in the same cycle wins over the clear.
    always_comb begin
        status_clr = `PMSE_EV_RST;
        if (reg_wr_en && reg_addr == `PMSE_ADDR_STATUS) begin
            status_clr = reg_wr_data[`PMSE_EV_W-1:0];
        end
        status_nxt = (status_r & ~status_clr) | event_set;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            status_r <= `PMSE_EV_RST;
            irq_r    <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq_r    <= |(status_nxt & mask_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Time base.

    pmse_tod_t tb_r;
    pmse_tod_t tb_nxt;
    logic      sec_r;
    logic      qtr_r;
    logic      day_r;

    always_comb begin
        if (element_time_preset) begin
            tb_nxt = pmse_back(element_time_of_day);
        end else begin
            tb_nxt = pmse_inc(tb_r);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sec_r <= 1'b0;
            qtr_r <= 1'b0;
            day_r <= 1'b0;
            tb_r  <= 17'h00000;
        end else begin
            sec_r <= element_time_tick;
            qtr_r <= 1'b0;
            day_r <= 1'b0;
            if (element_time_tick) begin
                tb_r  <= tb_nxt;
                qtr_r <= (tb_nxt % `PMSE_SEC_PER_QTR) == 17'h00000;
                day_r <= tb_nxt == pmse_qtr_start(start_qtr);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Near-end event unit.

    logic             ds_in;
    logic [EBC_W-1:0] ebc_in;
    logic [EBC_W-1:0] thr;
    logic             near_es;
    logic             near_ses;
    logic [EBC_W-1:0] near_bbe;
    logic             es_r;
    logic             ses_r;
    logic [EBC_W-1:0] bbe_r;

    always_comb begin
        ds_in    = ds_conn & defect_second_flag;
        ebc_in   = pmse_gate(ebc_conn, errored_block_count);
        thr      = video_layer ? THR_VIDEO : THR_STD;
        near_es  = ds_in | (ebc_in >= EBC_ONE);
        near_ses = ds_in | (ebc_in >= thr);
        near_bbe = near_ses ? EBC_ZERO : ebc_in;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            es_r  <= 1'b0;
            ses_r <= 1'b0;
            bbe_r <= EBC_ZERO;
        end else if (element_time_tick) begin
            es_r  <= near_es;
            ses_r <= near_ses;
            bbe_r <= near_bbe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Availability filter.

    logic             f_es;
    logic             f_ses;
    logic [EBC_W-1:0] f_bbe;
    logic             dly_es  [DEPTH];
    logic             dly_ses [DEPTH];
    logic [EBC_W-1:0] dly_bbe [DEPTH];
    pmse_avail_t      avail_r;
    logic [3:0]       run_r;
    logic             chg_r;
    logic             out_es_r;
    logic             out_ses_r;
    logic [EBC_W-1:0] out_bbe_r;
    logic             uas_r;

    always_comb begin
        f_es  = es_conn & near_es;
        f_ses = ses_conn & near_ses;
        f_bbe = pmse_gate(bbe_conn, near_bbe);
    end

    // The oldest entry is the second ten ticks back from the current one.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                dly_es[i]  <= 1'b0;
                dly_ses[i] <= 1'b0;
                dly_bbe[i] <= EBC_ZERO;
            end
        end else if (element_time_tick) begin
            for (int i = DEPTH - 1; i > 0; i--) begin
                dly_es[i]  <= dly_es[i-1];
                dly_ses[i] <= dly_ses[i-1];
                dly_bbe[i] <= dly_bbe[i-1];
            end
            dly_es[0]  <= f_es;
            dly_ses[0] <= f_ses;
            dly_bbe[0] <= f_bbe;
        end
    end

    // The run counts consecutive seconds that argue for leaving the current state.
    always_ff @(posedge clk) begin
        if (rst) begin
            avail_r <= PMSE_AVAILABLE;
            run_r   <= 4'h0;
            chg_r   <= 1'b0;
        end else begin
            chg_r <= 1'b0;
            if (element_time_tick) begin
                unique case (avail_r)
                    PMSE_AVAILABLE: begin
                        if (!f_ses) begin
                            run_r <= 4'h0;
                        end else if (run_r == `PMSE_UAT_RUN - 4'h1) begin
                            avail_r <= PMSE_UNAVAILABLE;
                            run_r   <= 4'h0;
                            chg_r   <= 1'b1;
                        end else begin
                            run_r <= run_r + 4'h1;
                        end
                    end
                    PMSE_UNAVAILABLE: begin
                        if (f_ses) begin
                            run_r <= 4'h0;
                        end else if (run_r == `PMSE_UAT_RUN - 4'h1) begin
                            avail_r <= PMSE_AVAILABLE;
                            run_r   <= 4'h0;
                            chg_r   <= 1'b1;
                        end else begin
                            run_r <= run_r + 4'h1;
                        end
                    end
                endcase
            end
        end
    end

    // The state decided up to the previous second governs the delayed second now leaving.
    always_ff @(posedge clk) begin
        if (rst) begin
            out_es_r  <= 1'b0;
            out_ses_r <= 1'b0;
            out_bbe_r <= EBC_ZERO;
            uas_r     <= 1'b0;
        end else if (element_time_tick) begin
            if (avail_r == PMSE_AVAILABLE) begin
                out_es_r  <= dly_es[DEPTH-1];
                out_ses_r <= dly_ses[DEPTH-1];
                out_bbe_r <= dly_bbe[DEPTH-1];
                uas_r     <= 1'b0;
            end else begin
                out_es_r  <= 1'b0;
                out_ses_r <= 1'b0;
                out_bbe_r <= EBC_ZERO;
                uas_r     <= 1'b1;
            end
        end
    end

    always_comb begin
        event_set                   = `PMSE_EV_RST;
        event_set[`PMSE_ST_UAT_CHG] = chg_r;
        event_set[`PMSE_ST_QTR]     = qtr_r;
        event_set[`PMSE_ST_DAY]     = day_r;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register read port.

    always_comb begin
        rd_mux = 32'h00000000;
        unique case (reg_addr)
            `PMSE_ADDR_CTRL:   rd_mux = ctrl_r;
            `PMSE_ADDR_STATUS: rd_mux[`PMSE_EV_W-1:0] = status_r;
            `PMSE_ADDR_MASK:   rd_mux[`PMSE_EV_W-1:0] = mask_r;
            `PMSE_ADDR_STATE: begin
                rd_mux[`PMSE_STATE_UAT] = avail_r == PMSE_UNAVAILABLE;
                rd_mux[`PMSE_STATE_RUN_HI:`PMSE_STATE_RUN_LO] = run_r;
                rd_mux[`PMSE_STATE_TB_HI:`PMSE_STATE_TB_LO]   = tb_r;
            end
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data_r <= 32'h00000000;
        end else if (reg_rd_en) begin
            rd_data_r <= rd_mux;
        end else begin
            rd_data_r <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign reg_rd_data                   = rd_data_r;
    assign irq                           = irq_r;
    assign second_tick                   = sec_r;
    assign quarter_hour_tick             = qtr_r;
    assign daily_tick                    = day_r;
    assign delayed_time_base             = tb_r;
    assign errored_second_event          = es_r;
    assign severe_errored_second_event   = ses_r;
    assign background_block_errors       = bbe_r;
    assign avail_errored_second          = out_es_r;
    assign avail_severe_errored_second   = out_ses_r;
    assign avail_background_block_errors = out_bbe_r;
    assign unavailable_second_out        = uas_r;
    assign unavailable_state             = avail_r == PMSE_UNAVAILABLE;
    assign unavailable_change            = chg_r;

endmodule : pmse_top
`default_nettype wire

/* File: shared/pmse_params.svh */
// Constants of the per-second performance monitoring block.
`ifndef PMSE_PARAMS_SVH
`define PMSE_PARAMS_SVH

`define PMSE_SEC_PER_DAY    17'h15180
`define PMSE_SEC_PER_QTR    17'h00384
`define PMSE_QTR_PER_DAY    7'h60
`define PMSE_TB_DELAY       17'h0000a
`define PMSE_DLY_DEPTH      10
`define PMSE_UAT_RUN        4'ha
`define PMSE_THR_STD        32'h00000960
`define PMSE_THR_VIDEO      32'h0000012c

`define PMSE_ADDR_CTRL      8'h00
`define PMSE_ADDR_STATUS    8'h04
`define PMSE_ADDR_MASK      8'h08
`define PMSE_ADDR_STATE     8'h0c

`define PMSE_CTRL_DS_CONN   0
`define PMSE_CTRL_EBC_CONN  1
`define PMSE_CTRL_BBE_CONN  2
`define PMSE_CTRL_ES_CONN   3
`define PMSE_CTRL_SES_CONN  4
`define PMSE_CTRL_VIDEO     5
`define PMSE_CTRL_START_LO  8
`define PMSE_CTRL_START_HI  14
`define PMSE_CTRL_RST       32'h0000001f

`define PMSE_ST_UAT_CHG     0
`define PMSE_ST_QTR         1
`define PMSE_ST_DAY         2
`define PMSE_EV_W           3
`define PMSE_EV_RST         3'h0

`define PMSE_STATE_UAT      0
`define PMSE_STATE_RUN_LO   4
`define PMSE_STATE_RUN_HI   7
`define PMSE_STATE_TB_LO    8
`define PMSE_STATE_TB_HI    24

`endif

/* File: shared/pmse_pkg.sv */
// Types shared by the per-second performance monitoring block.
`default_nettype none
package pmse_pkg;
    typedef logic [16:0] pmse_tod_t;
    typedef logic [6:0]  pmse_qtr_t;
    typedef enum logic {
        PMSE_AVAILABLE   = 1'b0,
        PMSE_UNAVAILABLE = 1'b1
    } pmse_avail_t;
endpackage : pmse_pkg
`default_nettype wire

/* File: verif/pmse_src.sv */
// Transport source model that hands over one second of defect data per request.
`default_nettype none
module pmse_src #(
    parameter int EBC_W = 16
) (
    input  wire logic             clk,
    input  wire logic             req,
    input  wire logic             req_ds,
    input  wire logic [EBC_W-1:0] req_ebc,
    output var  logic             tick,
    output var  logic             ds,
    output var  logic [EBC_W-1:0] ebc
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        tick = 1'b0;
        ds   = 1'b0;
        ebc  = '0;
    end
    // Outside the tick cycle the data lines invert on every clock, starting from the last value handed over.
    always @(posedge clk) begin
        tick <= req;
        ds   <= req ? req_ds : ~ds;
        ebc  <= req ? req_ebc : ~ebc;
    end
endmodule : pmse_src
`default_nettype wire

/* File: verif/pmse_top_sva.sv */
// Concurrent checks on the ports of the per-second monitoring block.
`default_nettype none
`include "pmse_params.svh"
module pmse_top_sva #(
    parameter int EBC_W = 16
) (
    input wire logic             clk,
    input wire logic             rst,
    input wire logic             element_time_tick,
    input wire logic             defect_second_flag,
    input wire logic [EBC_W-1:0] errored_block_count,
    input wire logic [7:0]       reg_addr,
    input wire logic [31:0]      reg_wr_data,
    input wire logic             reg_wr_en,
    input wire logic             second_tick,
    input wire logic             quarter_hour_tick,
    input wire logic             daily_tick,
    input wire logic [16:0]      delayed_time_base,
    input wire logic             errored_second_event,
    input wire logic             severe_errored_second_event,
    input wire logic             avail_errored_second,
    input wire logic             avail_severe_errored_second,
    input wire logic [EBC_W-1:0] avail_background_block_errors,
    input wire logic             unavailable_second_out,
    input wire logic             unavailable_state,
    input wire logic             unavailable_change
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0]      ctrl_r;
    logic [6:0]       start_q;
    logic             ds_v;
    logic [EBC_W-1:0] ebc_v;
    logic             es_v;
    logic             ses_v;
    // Shadow of the control word, so gating and threshold follow software.
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= `PMSE_CTRL_RST;
        end else if (reg_wr_en && reg_addr == `PMSE_ADDR_CTRL) begin
            ctrl_r <= reg_wr_data;
        end
    end
    assign start_q = (ctrl_r[14:8] >= 7'h60) ? 7'h00 : ctrl_r[14:8];
    assign ds_v    = defect_second_flag & ctrl_r[0];
    assign ebc_v   = ctrl_r[1] ? errored_block_count : '0;
    assign es_v    = ds_v || (ebc_v != '0);
    assign ses_v   = ds_v || (32'(ebc_v) >= (ctrl_r[5] ? `PMSE_THR_VIDEO : `PMSE_THR_STD));
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_tick_to_second: assert property (element_time_tick |=> second_tick)
        else $error("second tick missing");
    a_second_cause: assert property (second_tick |-> $past(element_time_tick))
        else $error("second tick without element tick");
    a_es_value: assert property (element_time_tick |=> errored_second_event == $past(es_v))
        else $error("errored second wrong");
    a_ses_value: assert property (
        element_time_tick |=> severe_errored_second_event == $past(ses_v))
        else $error("severe second wrong");
    a_events_hold: assert property (!second_tick |-> $stable(errored_second_event)
        && $stable(avail_background_block_errors) && $stable(delayed_time_base))
        else $error("state moved between ticks");
    a_uas_zeroes: assert property (unavailable_second_out |-> !avail_errored_second
        && !avail_severe_errored_second && avail_background_block_errors == '0)
        else $error("events passed in unavailable time");
    a_qtr_boundary: assert property ((second_tick || quarter_hour_tick) |-> second_tick
        && quarter_hour_tick == (delayed_time_base % `PMSE_SEC_PER_QTR == 17'h0))
        else $error("quarter tick misplaced");
    a_day_start: assert property ((second_tick || daily_tick) |-> second_tick
        && daily_tick == (delayed_time_base == 17'(start_q) * `PMSE_SEC_PER_QTR))
        else $error("daily tick misplaced");
    a_state_change: assert property ($changed(unavailable_state) |-> unavailable_change
        && second_tick)
        else $error("state change not reported");
endmodule : pmse_top_sva
bind pmse_top pmse_top_sva #(.EBC_W(EBC_W)) u_sva (
    .clk(clk), .rst(rst), .element_time_tick(element_time_tick),
    .defect_second_flag(defect_second_flag), .errored_block_count(errored_block_count),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_wr_en(reg_wr_en),
    .second_tick(second_tick), .quarter_hour_tick(quarter_hour_tick), .daily_tick(daily_tick),
    .delayed_time_base(delayed_time_base), .errored_second_event(errored_second_event),
    .severe_errored_second_event(severe_errored_second_event),
    .avail_errored_second(avail_errored_second),
    .avail_severe_errored_second(avail_severe_errored_second),
    .avail_background_block_errors(avail_background_block_errors),
    .unavailable_second_out(unavailable_second_out), .unavailable_state(unavailable_state),
    .unavailable_change(unavailable_change));
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench for the per-second monitoring block.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, req, req_ds, tick, ds, preset, wr_en, rd_en, irq;
    logic        sec_t, qtr_t, day_t, es_o, ses_o, aes_o, ases_o, uas_o, uat_o, chg_o;
    logic [15:0] req_ebc, ebc, bbe_o, abbe_o, ev;
    logic [16:0] tod, base_o;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, rv, seed;
    int          error_cnt, compares, ctrl, mask, st, base, cnt, uat, n, th;
    int          qe[$], qs[$], qb[$];
    int          ctab[10] = '{'h1f, 'h3f, 'h1e, 'h1d, 'h3b, 'h17, 'h0f, 'h3f, 'h1f, 'h3c};
    int          ptab[8]  = '{4509, 4510, 4511, 10, 9, 86399, 0, 910};
    int          blen[4]  = '{9, 10, 12, 3};

    pmse_src u_src (.clk(clk), .req(req), .req_ds(req_ds), .req_ebc(req_ebc),
        .tick(tick), .ds(ds), .ebc(ebc));
    pmse_top dut (.clk(clk), .rst(rst), .element_time_tick(tick), .element_time_preset(preset),
        .element_time_of_day(tod), .defect_second_flag(ds), .errored_block_count(ebc),
        .reg_addr(addr), .reg_wr_data(wdata), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_rd_data(rdata), .irq(irq), .second_tick(sec_t), .quarter_hour_tick(qtr_t),
        .daily_tick(day_t), .delayed_time_base(base_o), .errored_second_event(es_o),
        .severe_errored_second_event(ses_o), .background_block_errors(bbe_o),
        .avail_errored_second(aes_o), .avail_severe_errored_second(ases_o),
        .avail_background_block_errors(abbe_o), .unavailable_second_out(uas_o),
        .unavailable_state(uat_o), .unavailable_change(chg_o));

    ////////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        rv = rdata;
    endtask : rd
    // One second: the model below mirrors the event, filter and time base rules.
    task automatic sec(input logic d, input logic [15:0] e, input logic [16:0] t);
        int dv, es, ses, fe, fs, fb, old, chg, qtr, day;
        @(posedge clk);
        req     <= 1'b1;
        req_ds  <= d;
        req_ebc <= e;
        tod     <= t;
        @(posedge clk);
        req <= 1'b0;
        @(posedge clk);
        #1;
        dv   = d & ctrl[0];
        es   = dv || (ctrl[1] && e >= 1);
        ses  = dv || (ctrl[1] && e >= (ctrl[5] ? 300 : 2400));
        base = preset ? (t + 86390) % 86400 : (base + 1) % 86400;
        qtr  = base % 900 == 0;
        day  = base == ctrl[14:8] * 900;
        old  = uat;
        qe.push_back(es & ctrl[3]);
        qs.push_back(ses & ctrl[4]);
        qb.push_back((ctrl[2] && ctrl[1] && !ses) ? e : 0);
        fe   = qe.pop_front();
        fs   = qs.pop_front();
        fb   = qb.pop_front();
        cnt  = ((ses & ctrl[4]) != uat) ? cnt + 1 : 0;
        chg  = cnt == 10;
        if (chg) begin
            uat = !uat;
            cnt = 0;
        end
        st = st | chg | qtr << 1 | day << 2;
        chk(sec_t, 1);
        chk(es_o, es);
        chk(ses_o, ses);
        chk(bbe_o, (ctrl[1] && !ses) ? e : 0);
        chk(base_o, base);
        chk(qtr_t, qtr);
        chk(day_t, day);
        chk(aes_o, old ? 0 : fe);
        chk(ases_o, old ? 0 : fs);
        chk(abbe_o, old ? 0 : fb);
        chk(uas_o, old);
        chk(uat_o, uat);
        chk(chg_o, chg);
    endtask : sec

    ////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        test_done();
    end
    initial begin
        {rst, req, req_ds, req_ebc, tod, preset, wr_en, rd_en, addr, wdata} = '0;
        rst  = 1'b1;
        seed = 32'h23652a7f;
        ctrl = 'h1f;
        repeat (10) begin
            qe.push_back(0);
            qs.push_back(0);
            qb.push_back(0);
        end
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (n = 0; n < 5; n++) begin
            rd(8'(n * 4));
            chk(rv, n == 0 ? 32'h1f : 32'h0);
        end
        wr(8'h10, 32'hffffffff);
        wr(8'h00, 32'h0000601f);
        rd(8'h10);
        chk(rv, 32'h0);
        rd(8'h00);
        chk(rv, 32'h1f);
        mask = 2;
        wr(8'h08, 32'h2);
        $display("registers done");
        for (n = 0; n < 930; n++) begin
            if (n % 100 == 0) begin
                ctrl = ctab[n / 100];
                wr(8'h00, ctrl);
            end
            seed = lfsr(seed);
            th   = ctrl[5] ? 300 : 2400;
            ev   = seed[3:0];
            if (n / 25 % 2 == 1 && seed[31]) begin
                ev = seed[30] ? seed[15:0] : 16'(th - 2 + seed[1:0]);
            end
            sec(n % 25 < blen[n / 25 % 4], ev, 17'h0);
        end
        chk(irq, 1);
        rd(8'h04);
        chk(rv, st);
        wr(8'h04, st);
        st = 0;
        rd(8'h04);
        chk(rv, 0);
        chk(irq, 0);
        $display("second events done");
        @(posedge clk);
        preset <= 1'b1;
        for (n = 0; n < 16; n++) begin
            if (n % 8 == 0) begin
                ctrl = (n == 0) ? 'h51f : 'h1f;
                wr(8'h00, ctrl);
            end
            seed = lfsr(seed);
            sec(seed[0], 16'(seed[3:0]), 17'(ptab[n % 8]));
        end
        rd(8'h0c);
        chk(rv & 32'hffffff0f, base << 8 | uat);
        chk(irq, (st & mask) != 0);
        rd(8'h04);
        chk(rv, st);
        $display("preset time base done");
        test_done();
    end
endmodule : tb
`default_nettype wire
